//--- daq_trig_sync.sv
// Shared constants and the trigger synchroniser with rising-edge detection.
`timescale 1ns/1ps
`default_nettype none

package daq_host_pkg;
  localparam int ADDR_W = 5;
  localparam int DATA_W = 16;
  localparam int IRQ_W = 8;
  localparam int CNT_W = 6;
  localparam int CHAN_W = 3;
  localparam int NCHAN = 8;
  localparam logic [4:0] ADDR_INT_STATUS = 5'h0a;
  localparam logic [7:0] IRQ_RESET = 8'h00;
  localparam logic [15:0] DATA_RESET = 16'h0000;
  localparam logic [5:0] CNT_EMPTY = 6'h00;
endpackage : daq_host_pkg

module daq_trig_sync (
  // Clock and reset.
  input wire logic core_clk_i,
  input wire logic sys_rst_i,
  // Raw trigger pin level.
  input wire logic trig_i,
  // One-cycle pulse on a clean rising edge.
  output logic rise_o
);
  logic meta;
  logic sync;
  logic prev;

  // The first stage feeds only the second, so metastability never reaches the edge logic.
  always_ff @(posedge core_clk_i or posedge sys_rst_i) begin
    if (sys_rst_i) begin
      meta <= 1'b0;
      sync <= 1'b0;
      prev <= 1'b0;
    end else begin
      meta <= trig_i;
      sync <= meta;
      prev <= sync;
    end
  end

  assign rise_o = sync & ~prev;
endmodule : daq_trig_sync

`default_nettype wire

//--- daq_host_pin_interface.sv
// Host-side pin logic of the acquisition system: bus port, trigger pin, interrupt and DMA request.
`timescale 1ns/1ps
`default_nettype none

// What this block does
// - Trigger pin is input when direction low; its rising edge freezes the sample-and-hold.
// - On the clock edge after the freeze, start conversion or comparison per instruction.
// - Direction high makes trigger an output: high at operation start, low at completion.
// - Reset clears the direction setting so the trigger pin starts as an input.
// - Bus width high gives 8-bit bus, upper data lines undriven; low gives 16-bit.
// - Interrupt output goes low whenever any unmasked one of eight conditions occurs.
// - Reading the interrupt status register clears all pending interrupts and releases output.
// - Transfer request rises when FIFO occupancy equals the programmed count.
// - Transfer request falls once the host has emptied the FIFO.
// - Five select lines address registers, FIFO and instruction memory on every access.
// - Instruction picks channel: single-ended, or any two inputs as a differential pair.
// - Chip select low halts internal clocking and conversion; it resumes when high.
// - Data lines are driven only while read strobe and chip select are both low.
// - Data is accepted while store strobe and chip select are both low.
// - Falling address strobe latches address and select; held high on plain buses.
module daq_host_pin_interface (
  // Clock and reset.
  input wire logic core_clk_i,
  input wire logic sys_rst_i,
  // Host bus pins.
  input wire logic cs_n_i,
  input wire logic rd_n_i,
  input wire logic wr_n_i,
  input wire logic ale_i,
  input wire logic bus_width_select_i,
  input wire logic [4:0] register_select_lines_i,
  input wire logic [15:0] bus_data_lines_i,
  output logic [15:0] bus_data_lines_o,
  output logic [15:0] bus_data_lines_oe_n_o,
  // Trigger pin.
  input wire logic trig_i,
  output logic trig_o,
  output logic trig_oe_n_o,
  // Host notification pins.
  output logic int_n_o,
  output logic transfer_request_out_o,
  // Configuration levels.
  input wire logic io_select_i,
  input wire logic [7:0] irq_mask_i,
  input wire logic [5:0] dma_count_i,
  // Converter core status and instruction fields.
  input wire logic [7:0] irq_cond_i,
  input wire logic [5:0] fifo_count_i,
  input wire logic seq_start_i,
  input wire logic op_done_i,
  input wire logic instr_compare_i,
  input wire logic [2:0] chan_pos_i,
  input wire logic [2:0] chan_neg_i,
  input wire logic chan_diff_i,
  input wire logic [15:0] host_rdata_i,
  // Converter core controls.
  output logic hold_o,
  output logic conv_start_o,
  output logic cmp_start_o,
  output logic core_run_o,
  output logic [4:0] host_addr_o,
  output logic host_rd_o,
  output logic host_wr_o,
  output logic [15:0] host_wdata_o,
  output logic [7:0] mux_pos_o,
  output logic [7:0] mux_neg_o,
  output logic mux_neg_gnd_o
);
  function automatic logic [7:0] chan_onehot(input logic [2:0] sel);
    chan_onehot = 8'h01 << sel;
  endfunction : chan_onehot

  logic ale_q;
  logic [4:0] addr_lat;
  logic cs_lat_n;
  logic [7:0] pending;
  logic trig_dir;
  logic pend;
  logic trig_rise;

  daq_trig_sync u_trig_sync (
    .core_clk_i(core_clk_i),
    .sys_rst_i(sys_rst_i),
    .trig_i(trig_i),
    .rise_o(trig_rise)
  );

  // Address and select pass straight through while the strobe is high or just falling.
  wire ale_fall = ale_q & ~ale_i;
  wire ale_open = ale_i | ale_fall;
  wire [4:0] eff_addr = ale_open ? register_select_lines_i : addr_lat;
  wire eff_cs_n = ale_open ? cs_n_i : cs_lat_n;
  wire rd_act = ~eff_cs_n & ~rd_n_i;
  wire wr_act = ~eff_cs_n & ~wr_n_i;
  wire rd_start = rd_act & ~host_rd_o;
  wire status_read = rd_start & (eff_addr == daq_host_pkg::ADDR_INT_STATUS);
  wire [7:0] irq_hit = irq_cond_i & ~irq_mask_i;
  // A condition arriving in the clearing cycle survives, so no event is lost.
  wire [7:0] next_pending = (pending & ~{8{status_read}}) | irq_hit;
  wire [15:0] rd_word = status_read ? {8'h00, pending} : host_rdata_i;
  wire hi_drive = rd_act & ~bus_width_select_i;
  wire trig_rise_in = trig_rise & ~trig_dir;
  // Starts wait while chip select is low, since the core clock is stopped then.
  wire go = (trig_dir ? seq_start_i : pend) & cs_n_i & ~trig_o;
  wire dma_empty = (fifo_count_i == daq_host_pkg::CNT_EMPTY);
  wire dma_hit = (fifo_count_i == dma_count_i);

  always_ff @(posedge core_clk_i or posedge sys_rst_i) begin
    if (sys_rst_i) begin
      ale_q <= 1'b1;
      addr_lat <= 5'h00;
      cs_lat_n <= 1'b1;
    end else begin
      ale_q <= ale_i;
      if (ale_fall) begin
        addr_lat <= register_select_lines_i;
        cs_lat_n <= cs_n_i;
      end
    end
  end

  always_ff @(posedge core_clk_i or posedge sys_rst_i) begin
    if (sys_rst_i) begin
      host_addr_o <= 5'h00;
      host_rd_o <= 1'b0;
      host_wr_o <= 1'b0;
      host_wdata_o <= daq_host_pkg::DATA_RESET;
      bus_data_lines_o <= daq_host_pkg::DATA_RESET;
      bus_data_lines_oe_n_o <= 16'hffff;
    end else begin
      host_addr_o <= eff_addr;
      host_rd_o <= rd_act;
      host_wr_o <= wr_act;
      if (wr_act) begin
        host_wdata_o <= bus_width_select_i ? {8'h00, bus_data_lines_i[7:0]} : bus_data_lines_i;
      end
      if (rd_start) begin
        bus_data_lines_o <= rd_word;
      end
      bus_data_lines_oe_n_o <= {{8{~hi_drive}}, {8{~rd_act}}};
    end
  end

  always_ff @(posedge core_clk_i or posedge sys_rst_i) begin
    if (sys_rst_i) begin
      pending <= daq_host_pkg::IRQ_RESET;
      int_n_o <= 1'b1;
      transfer_request_out_o <= 1'b0;
    end else begin
      pending <= next_pending;
      int_n_o <= ~|next_pending;
      if (dma_empty) begin
        transfer_request_out_o <= 1'b0;
      end else if (dma_hit) begin
        transfer_request_out_o <= 1'b1;
      end
    end
  end

  always_ff @(posedge core_clk_i or posedge sys_rst_i) begin
    if (sys_rst_i) begin
      trig_dir <= 1'b0;
      trig_oe_n_o <= 1'b1;
      trig_o <= 1'b0;
      pend <= 1'b0;
      hold_o <= 1'b0;
      conv_start_o <= 1'b0;
      cmp_start_o <= 1'b0;
      core_run_o <= 1'b0;
    end else begin
      trig_dir <= io_select_i;
      trig_oe_n_o <= ~trig_dir;
      hold_o <= trig_rise_in;
      pend <= trig_rise_in | (pend & ~go & ~trig_dir);
      conv_start_o <= go & ~instr_compare_i;
      cmp_start_o <= go & instr_compare_i;
      core_run_o <= cs_n_i;
      if (go) begin
        trig_o <= 1'b1;
      end else if (op_done_i) begin
        trig_o <= 1'b0;
      end
    end
  end

  always_ff @(posedge core_clk_i or posedge sys_rst_i) begin
    if (sys_rst_i) begin
      mux_pos_o <= 8'h00;
      mux_neg_o <= 8'h00;
      mux_neg_gnd_o <= 1'b1;
    end else begin
      mux_pos_o <= chan_onehot(chan_pos_i);
      mux_neg_o <= chan_diff_i ? chan_onehot(chan_neg_i) : 8'h00;
      mux_neg_gnd_o <= ~chan_diff_i;
    end
  end

  default clocking cb @(posedge core_clk_i); endclocking
  default disable iff (sys_rst_i);

  property p_hold_on_edge;
    trig_rise_in |=> hold_o;
  endproperty
  a_hold_on_edge: assert property (p_hold_on_edge) else $error("no freeze after edge");

  property p_start_next;
    pend && !trig_dir && cs_n_i && !trig_o |=> (conv_start_o || cmp_start_o);
  endproperty
  a_start_next: assert property (p_start_next) else $error("start missed");

  property p_trig_out_busy;
    (conv_start_o || cmp_start_o) |-> trig_o;
  endproperty
  a_trig_out_busy: assert property (p_trig_out_busy) else $error("trigger not high");

  property p_dir_in;
    !io_select_i ##1 !io_select_i |=> trig_oe_n_o;
  endproperty
  a_dir_in: assert property (p_dir_in) else $error("trigger driven");

  property p_hi_float;
    bus_width_select_i |=> &bus_data_lines_oe_n_o[15:8];
  endproperty
  a_hi_float: assert property (p_hi_float) else $error("upper lines driven");

  property p_int_assert;
    irq_hit != 8'h00 |=> !int_n_o;
  endproperty
  a_int_assert: assert property (p_int_assert) else $error("interrupt missed");

  property p_int_clear;
    status_read && irq_hit == 8'h00 |=> int_n_o;
  endproperty
  a_int_clear: assert property (p_int_clear) else $error("interrupt not cleared");

  property p_dma_set;
    dma_hit && !dma_empty |=> transfer_request_out_o;
  endproperty
  a_dma_set: assert property (p_dma_set) else $error("request not raised");

  property p_dma_clr;
    dma_empty |=> !transfer_request_out_o;
  endproperty
  a_dma_clr: assert property (p_dma_clr) else $error("request not dropped");

  property p_halt;
    !cs_n_i |=> !conv_start_o && !cmp_start_o && !core_run_o;
  endproperty
  a_halt: assert property (p_halt) else $error("ran while selected");

  property p_no_drive;
    !rd_act |=> &bus_data_lines_oe_n_o;
  endproperty
  a_no_drive: assert property (p_no_drive) else $error("bus driven idle");

  property p_addr_latch;
    ale_fall |=> host_addr_o == $past(register_select_lines_i);
  endproperty
  a_addr_latch: assert property (p_addr_latch) else $error("address not latched");

  property p_single_ended;
    !chan_diff_i |=> mux_neg_gnd_o && mux_neg_o == 8'h00;
  endproperty
  a_single_ended: assert property (p_single_ended) else $error("bad single-ended");

  c_trig_conv: cover property (trig_rise_in ##[1:8] conv_start_o);
  c_status_read: cover property (!int_n_o ##1 status_read ##1 int_n_o);
  c_dma_cycle: cover property (transfer_request_out_o ##[1:64] !transfer_request_out_o);
endmodule : daq_host_pin_interface

`default_nettype wire

//--- host_bus_model.sv
// Host processor model driving the plain and multiplexed bus strobes of the port.
`timescale 1ns/1ps
`default_nettype none
module host_bus_model (
  // Clock.
  input wire logic clk_i,
  // Device read data.
  input wire logic [15:0] rdata_i,
  // Strobes, address and write data.
  output logic cs_n_o,
  output logic rd_n_o,
  output logic wr_n_o,
  output logic ale_o,
  output logic [4:0] addr_o,
  output logic [15:0] wdata_o
);
  initial begin
    cs_n_o = 1'b1;
    rd_n_o = 1'b1;
    wr_n_o = 1'b1;
    ale_o = 1'b1;
    addr_o = 5'h1f;
    wdata_o = 16'h0000;
  end
  // Strobes stand four edges so the registered answer settles before release.
  task automatic access(input logic wr, input logic [4:0] a, input logic [15:0] d,
                        output logic [15:0] q);
    @(posedge clk_i);
    cs_n_o <= 1'b0;
    rd_n_o <= wr;
    wr_n_o <= !wr;
    addr_o <= a;
    wdata_o <= d;
    repeat (4) @(posedge clk_i);
    #1;
    q = rdata_i;
    @(posedge clk_i);
    cs_n_o <= 1'b1;
    rd_n_o <= 1'b1;
    wr_n_o <= 1'b1;
    addr_o <= ~a;
    // A released bus shows the inverse, never a stale match.
    wdata_o <= ~d;
  endtask : access
  // A multiplexed read: the falling strobe latches address and select, then the pins move on.
  task automatic access_mux(input logic [4:0] a, output logic [15:0] q);
    @(posedge clk_i);
    cs_n_o <= 1'b0;
    addr_o <= a;
    @(posedge clk_i);
    ale_o <= 1'b0;
    @(posedge clk_i);
    addr_o <= ~a;
    rd_n_o <= 1'b0;
    repeat (4) @(posedge clk_i);
    #1;
    q = rdata_i;
    @(posedge clk_i);
    ale_o <= 1'b1;
    cs_n_o <= 1'b1;
    rd_n_o <= 1'b1;
  endtask : access_mux
endmodule : host_bus_model
`default_nettype wire

//--- testbench.sv
// Self-checking bench for the host pin interface.
`timescale 1ns/1ps
`default_nettype none
`define CHK(n, e, g) begin comparisons++; if ((g) !== (e)) begin err_count++; \
  $display("MISMATCH %s exp %h got %h", n, e, g); end end
module testbench;
  logic core_clk_i = 1'b0;
  logic sys_rst_i = 1'b1;
  logic cs_n, rd_n, wr_n, ale, t_o, t_oe_n, int_n, dreq, hold, conv, cst, run, hrd, hwr, gnd;
  logic [4:0] addr, haddr;
  logic [15:0] wd, dout, oe_n, hwd, q;
  logic [15:0] rdata = 16'h0000;
  logic bw = 1'b0, trig = 1'b0, io_sel = 1'b1, seq = 1'b0, done = 1'b0, cmp = 1'b0;
  logic diff = 1'b0;
  logic [7:0] mask = 8'h00, cond = 8'h00, mp, mn;
  logic [5:0] dcnt = 6'h04, fcnt = 6'h00;
  logic [2:0] cp = 3'h0, cn = 3'h0;
  int err_count = 0, comparisons = 0, cycles = 0;
  host_bus_model host_bus_model_inst (.clk_i(core_clk_i), .rdata_i(dout), .cs_n_o(cs_n),
    .rd_n_o(rd_n), .wr_n_o(wr_n), .ale_o(ale), .addr_o(addr), .wdata_o(wd));
  daq_host_pin_interface daq_host_pin_interface_inst (.core_clk_i, .sys_rst_i, .cs_n_i(cs_n),
    .rd_n_i(rd_n), .wr_n_i(wr_n), .ale_i(ale), .bus_width_select_i(bw),
    .register_select_lines_i(addr), .bus_data_lines_i(wd), .bus_data_lines_o(dout),
    .bus_data_lines_oe_n_o(oe_n), .trig_i(trig), .trig_o(t_o), .trig_oe_n_o(t_oe_n),
    .int_n_o(int_n), .transfer_request_out_o(dreq), .io_select_i(io_sel), .irq_mask_i(mask),
    .dma_count_i(dcnt), .irq_cond_i(cond), .fifo_count_i(fcnt), .seq_start_i(seq),
    .op_done_i(done), .instr_compare_i(cmp), .chan_pos_i(cp), .chan_neg_i(cn),
    .chan_diff_i(diff), .host_rdata_i(rdata), .hold_o(hold), .conv_start_o(conv),
    .cmp_start_o(cst), .core_run_o(run), .host_addr_o(haddr), .host_rd_o(hrd),
    .host_wr_o(hwr), .host_wdata_o(hwd), .mux_pos_o(mp), .mux_neg_o(mn), .mux_neg_gnd_o(gnd));
  // This is the block's own clock; the slow converter clock the host must keep in range lies beyond it.
  always #4 core_clk_i = ~core_clk_i;
  task automatic stop_test();
    $display("Counts: %0d mismatches, %0d comparisons", err_count, comparisons);
    if (err_count == 0 && comparisons > 0) $display("All tests passed");
    else $display("Some tests failed");
    $finish;
  endtask : stop_test
  // The whole run needs well under a thousand cycles.
  always @(posedge core_clk_i) begin
    cycles <= cycles + 1;
    if (cycles == 3000) begin
      err_count++;
      stop_test();
    end
  end
  task automatic tick(input int n);
    repeat (n) @(posedge core_clk_i);
    #1;
  endtask : tick
  task automatic t_reset();
    tick(7);
    `CHK("trig_oe_n", 1'b1, t_oe_n)
    `CHK("int_n", 1'b1, int_n)
    `CHK("oe_n", 16'hffff, oe_n)
    `CHK("dreq", 1'b0, dreq)
    @(posedge core_clk_i);
    sys_rst_i <= 1'b0;
    io_sel <= 1'b0;
    tick(3);
    `CHK("trig_oe_n", 1'b1, t_oe_n)
  endtask : t_reset
  task automatic t_read(input logic w8);
    @(posedge core_clk_i);
    bw <= w8;
    rdata <= 16'hbeef;
    fork
      host_bus_model_inst.access(1'b0, 5'h03, 16'h0000, q);
      begin
        tick(4);
        `CHK("oe_n", w8 ? 16'hff00 : 16'h0000, oe_n)
        `CHK("haddr", 5'h03, haddr)
        `CHK("hrd", 1'b1, hrd)
        `CHK("run", 1'b0, run)
      end
    join
    `CHK("q", 8'hef, q[7:0])
    if (!w8) `CHK("q_hi", 8'hbe, q[15:8])
    tick(3);
    `CHK("oe_n", 16'hffff, oe_n)
    `CHK("hrd", 1'b0, hrd)
    `CHK("run", 1'b1, run)
  endtask : t_read
  task automatic t_write(input logic w8);
    @(posedge core_clk_i);
    bw <= w8;
    fork
      host_bus_model_inst.access(1'b1, 5'h05, 16'h5aa5, q);
      begin
        tick(4);
        `CHK("hwr", 1'b1, hwr)
        `CHK("hwd", w8 ? 16'h00a5 : 16'h5aa5, hwd)
        `CHK("oe_n", 16'hffff, oe_n)
        `CHK("haddr", 5'h05, haddr)
      end
    join
  endtask : t_write
  task automatic t_mux_bus();
    @(posedge core_clk_i);
    rdata <= 16'h1234;
    fork
      host_bus_model_inst.access_mux(5'h06, q);
      begin
        tick(5);
        `CHK("haddr", 5'h06, haddr)
        `CHK("oe_n", 16'h0000, oe_n)
      end
    join
    `CHK("q", 16'h1234, q)
  endtask : t_mux_bus
  task automatic t_irq();
    @(posedge core_clk_i);
    bw <= 1'b0;
    mask <= 8'h01;
    cond <= 8'h01;
    @(posedge core_clk_i);
    cond <= 8'h04;
    @(posedge core_clk_i);
    cond <= 8'h00;
    tick(3);
    `CHK("int_n", 1'b0, int_n)
    host_bus_model_inst.access(1'b0, 5'h0a, 16'h0000, q);
    `CHK("status", 16'h0004, q)
    tick(2);
    `CHK("int_n", 1'b1, int_n)
  endtask : t_irq
  task automatic t_dma();
    @(posedge core_clk_i);
    fcnt <= 6'h04;
    tick(3);
    `CHK("dreq", 1'b1, dreq)
    @(posedge core_clk_i);
    fcnt <= 6'h02;
    tick(3);
    `CHK("dreq", 1'b1, dreq)
    @(posedge core_clk_i);
    fcnt <= 6'h00;
    tick(3);
    `CHK("dreq", 1'b0, dreq)
  endtask : t_dma
  task automatic t_trig(input logic c);
    int n;
    n = 0;
    @(posedge core_clk_i);
    cmp <= c;
    trig <= 1'b1;
    while (hold !== 1'b1 && n < 8) begin
      tick(1);
      n++;
    end
    `CHK("hold", 1'b1, hold)
    tick(1);
    `CHK("conv", !c, conv)
    `CHK("cmp", c, cst)
    @(posedge core_clk_i);
    trig <= 1'b0;
    done <= 1'b1;
    @(posedge core_clk_i);
    done <= 1'b0;
    tick(2);
    `CHK("hold", 1'b0, hold)
  endtask : t_trig
  task automatic t_out();
    int n;
    n = 0;
    @(posedge core_clk_i);
    io_sel <= 1'b1;
    tick(3);
    `CHK("trig_oe_n", 1'b0, t_oe_n)
    @(posedge core_clk_i);
    seq <= 1'b1;
    while (t_o !== 1'b1 && n < 6) begin
      tick(1);
      n++;
    end
    `CHK("trig_o", 1'b1, t_o)
    @(posedge core_clk_i);
    seq <= 1'b0;
    done <= 1'b1;
    @(posedge core_clk_i);
    done <= 1'b0;
    tick(2);
    `CHK("trig_o", 1'b0, t_o)
  endtask : t_out
  task automatic t_mux();
    @(posedge core_clk_i);
    cp <= 3'h5;
    cn <= 3'h2;
    diff <= 1'b1;
    tick(3);
    `CHK("pos", 8'h20, mp)
    `CHK("neg", 8'h04, mn)
    `CHK("gnd", 1'b0, gnd)
    @(posedge core_clk_i);
    cp <= 3'h7;
    diff <= 1'b0;
    tick(3);
    `CHK("pos", 8'h80, mp)
    `CHK("gnd", 1'b1, gnd)
  endtask : t_mux
  initial begin
    t_reset();
    t_read(1'b0);
    t_read(1'b1);
    t_write(1'b1);
    t_write(1'b0);
    t_mux_bus();
    t_irq();
    t_dma();
    t_trig(1'b0);
    t_trig(1'b1);
    t_out();
    t_mux();
    stop_test();
  end
endmodule : testbench
`default_nettype wire
